// *** fsl_ctrl.sv ***
`default_nettype none
// Functional notes
// RL1: after erase suspend, poll until ready and erase-suspended both set
// RL2: erase done before suspend: issue status read, check erase-suspended flag
// RL3: during erase suspend the device serves reads and writes to other blocks
// RL4: write under erase suspend shows busy with erase-suspended still set
// RL5: under erase suspend only status read and resume commands are issued; the code also issues write suspend (OP_WR_SUSP)
// RL6: erase resume restarts erase; device clears ready and suspended flags
// RL7: erase resume waits until writes started in suspension finish
// RL8: keep reset pin high and write protect unchanged during erase suspend
// RL9: keep resume and next suspend apart by at least the resume interval; the code checks the gap (ERES_GAP) only before the next erase resume
// RL10: after write suspend, poll until ready and write-suspended both set
// RL11: write done before suspend: issue status read, check write-suspended
// RL12: under write suspend only reads, status read and write resume issued
// RL13: write resume continues programming; device clears both flags
// RL14: lock bits and write protect gate changes; permanent lock freezes them
// RL15: lock set is setup write then confirm; block confirm in target block
// RL16: after lock set poll ready, then check write/setlock error flag
// RL17: improper lock sequence sets both error flags
// RL18: lock change with permanent lock set fails with protect flag
// RL19: clear lock command clears all block lock bits at once
// RL20: after clear lock poll ready, then check erase/clear error flag
// RL21: clear with low program supply sets supply-low and clear error
// RL22: aborted clear leaves lock bits undefined; host must repeat clear
// RL23: permanent lock bit can never be cleared
// RL24: lower status bits are only meaningful once ready reads one
// RL25: error flags cleared by 50h, never sent while suspended
// RL26: command byte codes are configurable constants
module fsl_ctrl
  import fsl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [1:0]  sw_addr_i,
  input  wire logic [31:0] sw_wdata_i,
  input  wire logic        sw_write_i,
  input  wire logic        sw_read_i,
  output var  logic [31:0] sw_rdata_o,
  input  wire logic [15:0] dq_in_i,
  output var  logic [15:0] dq_out_o,
  output var  logic        dq_oe_o,
  output var  logic [19:0] flash_addr_o,
  output var  logic        we_n_o,
  output var  logic        oe_n_o,
  output var  logic        reset_powerdown_n_o,
  output var  logic        write_protect_n_o
);
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_CLR, S_CMD1, S_CMD2, S_RSR, S_POLL, S_EVAL, S_DONE
  } fsl_st_e;

  fsl_st_e     st_reg, st_next;
  logic [2:0]  op_reg, op_next;
  logic [19:0] ad_reg, ad_next;
  logic [7:0]  sr_reg, sr_next;
  logic [15:0] pol_reg, pol_next;
  logic [7:0]  gap_reg, gap_next;
  logic        esusp_reg, esusp_next;
  logic        wsusp_reg, wsusp_next;
  logic        wp_reg, wp_next;
  logic        busy_reg, busy_next;
  logic        ok_reg, ok_next;
  logic        tmo_reg, tmo_next;
  logic        rej_reg, rej_next;
  logic [31:0] rd_reg, rd_next;
  logic        bc_start, bc_write, bc_done;
  logic [7:0]  bc_data, bc_rdata;
  logic [19:0] bc_addr;
  logic        legal;

  // legality of a new op against the suspend state
  always_comb begin
    unique case (sw_wdata_i[2:0])
      OP_ERS_SUSP:  legal = !esusp_reg && !wsusp_reg;
      OP_ERS_RES:   legal = esusp_reg && !wsusp_reg && gap_reg == 8'h00; // RL5 RL7
      OP_WR_SUSP:   legal = !wsusp_reg;
      OP_WR_RES:    legal = wsusp_reg;                                  // RL12
      default:      legal = !esusp_reg && !wsusp_reg;                   // RL5
    endcase
  end

  always_comb begin
    st_next    = st_reg;
    op_next    = op_reg;
    ad_next    = ad_reg;
    sr_next    = sr_reg;
    pol_next   = pol_reg;
    gap_next   = (gap_reg != 8'h00) ? gap_reg - 8'h01 : gap_reg;
    esusp_next = esusp_reg;
    wsusp_next = wsusp_reg;
    wp_next    = wp_reg;
    busy_next  = busy_reg;
    ok_next    = ok_reg;
    tmo_next   = tmo_reg;
    rej_next   = rej_reg;
    bc_start   = 1'b0;
    bc_write   = 1'b1;
    bc_data    = CMD_READ_STATUS;
    bc_addr    = ad_reg;
    if (sw_write_i && sw_addr_i == REG_ADDR && !busy_reg) begin
      ad_next = sw_wdata_i[19:0];
    end
    if (sw_write_i && sw_addr_i == REG_CTRL && !esusp_reg && !busy_reg) begin
      wp_next = sw_wdata_i[8]; // RL8
    end
    unique case (st_reg)
      S_IDLE: if (sw_write_i && sw_addr_i == REG_CTRL && !busy_reg) begin
        // a refused op also replaces the old result, so ok never lingers
        rej_next = !legal || sw_wdata_i[2:0] == 3'h0;
        ok_next  = 1'b0;
        tmo_next = 1'b0;
        if (legal && sw_wdata_i[2:0] != 3'h0) begin
          op_next   = sw_wdata_i[2:0];
          busy_next = 1'b1;
          // error flags cleared only outside suspend
          st_next   = (!esusp_reg && !wsusp_reg) ? S_CLR : S_CMD1; // RL25
        end
      end
      S_CLR: begin
        bc_start = 1'b1;
        bc_data  = CMD_CLEAR_STATUS; // RL25
        if (bc_done) st_next = S_CMD1;
      end
      S_CMD1: begin
        bc_start = 1'b1;
        unique case (op_reg)
          OP_ERS_SUSP, OP_WR_SUSP: bc_data = CMD_SUSPEND;
          OP_ERS_RES, OP_WR_RES:   bc_data = CMD_RESUME;
          default:                 bc_data = CMD_LOCK_SETUP; // RL15
        endcase
        if (bc_done) begin
          unique case (op_reg)
            OP_BLK_LOCK, OP_PERM_LOCK, OP_CLR_LOCK: st_next = S_CMD2;
            default: st_next = S_RSR; // RL2 RL11
          endcase
        end
      end
      S_CMD2: begin
        // block confirm carries target address, others any address
        bc_start = 1'b1; // RL15
        unique case (op_reg)
          OP_BLK_LOCK:  bc_data = CMD_BLK_LOCK_CF;
          OP_PERM_LOCK: bc_data = CMD_PERM_LOCK_CF;
          default:      bc_data = CMD_CLR_LOCK_CF; // RL19 RL22
        endcase
        if (bc_done) st_next = S_RSR;
      end
      S_RSR: begin
        bc_start = 1'b1;
        if (bc_done) begin
          st_next  = S_POLL;
          pol_next = POLL_MAX;
        end
      end
      S_POLL: begin
        bc_start = 1'b1;
        bc_write = 1'b0;
        if (bc_done) begin
          sr_next  = bc_rdata;
          pol_next = pol_reg - 16'h0001;
          // lower bits ignored until ready reads one
          if (bc_rdata[SR_READY]) st_next = S_EVAL; // RL24 RL16 RL20
          else if (pol_reg == 16'h0001) begin
            tmo_next = 1'b1;
            st_next  = S_DONE;
          end
        end
      end
      S_EVAL: begin
        st_next = S_DONE;
        unique case (op_reg)
          OP_ERS_SUSP: begin
            esusp_next = sr_reg[SR_ERS_SUSP]; // RL1 RL2 RL3
            ok_next    = 1'b1;
          end
          OP_WR_SUSP: begin
            wsusp_next = sr_reg[SR_WR_SUSP]; // RL10 RL11 RL4
            ok_next    = 1'b1;
          end
          OP_ERS_RES: begin
            esusp_next = 1'b0; // RL6
            gap_next   = ERES_GAP; // RL9
            ok_next    = !sr_reg[SR_ERS_CLR];
          end
          OP_WR_RES: begin
            wsusp_next = 1'b0; // RL13
            ok_next    = !sr_reg[SR_WR_SETLK];
          end
          OP_CLR_LOCK: ok_next = !sr_reg[SR_ERS_CLR]; // RL20 RL21
          default: ok_next = !sr_reg[SR_WR_SETLK]; // RL16 RL17 RL18 RL14
        endcase
      end
      S_DONE: begin
        busy_next = 1'b0;
        st_next   = S_IDLE;
      end
      default: st_next = S_IDLE;
    endcase
    // ----------------------------------------------------------------
    // software read port
    // ----------------------------------------------------------------
    rd_next = 32'h0000_0000;
    if (sw_read_i) begin
      unique case (sw_addr_i)
        REG_CTRL:   rd_next = {23'h0, wp_reg, 5'h0, op_reg};
        REG_ADDR:   rd_next = {12'h0, ad_reg};
        REG_STATUS: rd_next = {24'h0, sr_reg};
        REG_RESULT: rd_next = {26'h0, rej_reg, tmo_reg, wsusp_reg,
                               esusp_reg, ok_reg, busy_reg};
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= S_IDLE; op_reg <= '0; ad_reg <= '0; sr_reg <= '0;
      pol_reg <= '0; gap_reg <= '0; esusp_reg <= 1'b0; wsusp_reg <= 1'b0;
      wp_reg <= 1'b1; busy_reg <= 1'b0; ok_reg <= 1'b0; tmo_reg <= 1'b0;
      rej_reg <= 1'b0; rd_reg <= '0;
    end else begin
      st_reg <= st_next; op_reg <= op_next; ad_reg <= ad_next;
      sr_reg <= sr_next; pol_reg <= pol_next; gap_reg <= gap_next;
      esusp_reg <= esusp_next; wsusp_reg <= wsusp_next; wp_reg <= wp_next;
      busy_reg <= busy_next; ok_reg <= ok_next; tmo_reg <= tmo_next;
      rej_reg <= rej_next; rd_reg <= rd_next;
    end
  end

  // reset pin only released after our own reset, never pulsed by us
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reset_powerdown_n_o <= 1'b0;
      write_protect_n_o   <= 1'b1;
    end else begin
      reset_powerdown_n_o <= 1'b1; // RL8
      write_protect_n_o   <= wp_next;
    end
  end
  assign sw_rdata_o = rd_reg;

  fsl_bus_cycle u_cycle (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .start_i  (bc_start && !bc_done),
    .write_i  (bc_write),
    .addr_i   (bc_addr),
    .data_i   (bc_data),
    .dq_in_i  (dq_in_i),
    .done_o   (bc_done),
    .rdata_o  (bc_rdata),
    .addr_o   (flash_addr_o),
    .dq_out_o (dq_out_o),
    .dq_oe_o  (dq_oe_o),
    .we_n_o   (we_n_o),
    .oe_n_o   (oe_n_o)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_NO_CLR_IN_SUSP: assert property ( // RL25
    @(posedge clk_i) disable iff (reset_i)
    (st_reg == S_CLR) |-> (!esusp_reg && !wsusp_reg))
    else $error("clear status issued while suspended");
  AST_RES_WAIT_WR: assert property ( // RL7
    @(posedge clk_i) disable iff (reset_i)
    (st_reg == S_CMD1 && op_reg == OP_ERS_RES) |-> !wsusp_reg)
    else $error("erase resume while write suspended");
  AST_GAP: assert property ( // RL9
    @(posedge clk_i) disable iff (reset_i)
    (st_reg == S_EVAL && op_reg == OP_ERS_RES) |=> (gap_reg == ERES_GAP))
    else $error("resume gap not armed");
  AST_RSTPIN: assert property ( // RL8
    @(posedge clk_i) disable iff (reset_i)
    !$past(reset_i) |-> reset_powerdown_n_o)
    else $error("reset pin dropped");
  AST_WP_HOLD: assert property ( // RL8
    @(posedge clk_i) disable iff (reset_i)
    esusp_reg && $past(esusp_reg) |-> $stable(write_protect_n_o))
    else $error("write protect moved in erase suspend");
  AST_ESUSP_SET: assert property ( // RL1
    @(posedge clk_i) disable iff (reset_i)
    (st_reg == S_EVAL && op_reg == OP_ERS_SUSP) |=>
    esusp_reg == $past(sr_reg[SR_ERS_SUSP]))
    else $error("erase suspend state wrong");
  AST_WSUSP_CLR: assert property ( // RL13
    @(posedge clk_i) disable iff (reset_i)
    (st_reg == S_EVAL && op_reg == OP_WR_RES) |=> !wsusp_reg)
    else $error("write suspend not cleared");
  AST_LOCK_TWO: assert property ( // RL15
    @(posedge clk_i) disable iff (reset_i)
    (st_reg == S_CMD1 && bc_done && op_reg == OP_CLR_LOCK) |=>
    st_reg == S_CMD2)
    else $error("lock confirm skipped");
endmodule
`default_nettype wire

// *** fsl_pkg.sv ***
`default_nettype none
package fsl_pkg;
  // command codes; all configurable constants, 70h and 50h included
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_SUSPEND      = 8'hb0;
  localparam logic [7:0] CMD_RESUME       = 8'hd0;
  localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
  localparam logic [7:0] CMD_BLK_LOCK_CF  = 8'h01;
  localparam logic [7:0] CMD_PERM_LOCK_CF = 8'hf1;
  localparam logic [7:0] CMD_CLR_LOCK_CF  = 8'hd0;
  // status bit positions
  localparam int SR_READY     = 7;
  localparam int SR_ERS_SUSP  = 6;
  localparam int SR_ERS_CLR   = 5;
  localparam int SR_WR_SETLK  = 4;
  localparam int SR_SUPPLY_LO = 3;
  localparam int SR_WR_SUSP   = 2;
  localparam int SR_PROTECT   = 1;
  // software register offsets
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_ADDR   = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [1:0] REG_RESULT = 2'h3;
  // ctrl op codes
  localparam logic [2:0] OP_ERS_SUSP  = 3'h1;
  localparam logic [2:0] OP_ERS_RES   = 3'h2;
  localparam logic [2:0] OP_WR_SUSP   = 3'h3;
  localparam logic [2:0] OP_WR_RES    = 3'h4;
  localparam logic [2:0] OP_BLK_LOCK  = 3'h5;
  localparam logic [2:0] OP_PERM_LOCK = 3'h6;
  localparam logic [2:0] OP_CLR_LOCK  = 3'h7;
  // bus cycle phase length in clocks (100 ns each)
  localparam int PHASE_NS     = 100;
  localparam int CLK_NS       = 100;
  localparam int PHASE_CYC    = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] PHASE_CNT = 4'(PHASE_CYC);
  // poll limit in polls and min resume interval in clocks
  localparam logic [15:0] POLL_MAX  = 16'hffff;
  localparam logic [7:0]  ERES_GAP  = 8'h10;
endpackage
`default_nettype wire

// *** fsl_bus_cycle.sv ***
`default_nettype none
// one flash bus write or status read, each phase PHASE_CNT clocks
module fsl_bus_cycle
  import fsl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        start_i,
  input  wire logic        write_i,
  input  wire logic [19:0] addr_i,
  input  wire logic [7:0]  data_i,
  input  wire logic [15:0] dq_in_i,
  output var  logic        done_o,
  output var  logic [7:0]  rdata_o,
  output var  logic [19:0] addr_o,
  output var  logic [15:0] dq_out_o,
  output var  logic        dq_oe_o,
  output var  logic        we_n_o,
  output var  logic        oe_n_o
);
  typedef enum logic [1:0] {BC_IDLE, BC_ACT, BC_REC} fsl_bc_e;
  fsl_bc_e     st_reg, st_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic        wr_reg, wr_next;
  logic [7:0]  rd_reg, rd_next;
  logic [19:0] a_reg, a_next;
  logic [7:0]  d_reg, d_next;
  logic        done_reg, done_next;

  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    wr_next   = wr_reg;
    rd_next   = rd_reg;
    a_next    = a_reg;
    d_next    = d_reg;
    done_next = 1'b0;
    unique case (st_reg)
      BC_IDLE: if (start_i) begin
        st_next  = BC_ACT;
        cnt_next = PHASE_CNT;
        wr_next  = write_i;
        a_next   = addr_i;
        d_next   = data_i;
      end
      BC_ACT: if (cnt_reg == 4'h1) begin
        st_next  = BC_REC;
        cnt_next = PHASE_CNT;
        if (!wr_reg) rd_next = dq_in_i[7:0];
      end else begin
        cnt_next = cnt_reg - 4'h1;
      end
      BC_REC: if (cnt_reg == 4'h1) begin
        st_next   = BC_IDLE;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 4'h1;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= BC_IDLE; cnt_reg <= '0; wr_reg <= 1'b0; rd_reg <= '0;
      a_reg <= '0; d_reg <= '0; done_reg <= 1'b0;
    end else begin
      st_reg <= st_next; cnt_reg <= cnt_next; wr_reg <= wr_next;
      rd_reg <= rd_next; a_reg <= a_next; d_reg <= d_next;
      done_reg <= done_next;
    end
  end

  // data held through recovery so it is stable at the write's rising edge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      we_n_o <= 1'b1; oe_n_o <= 1'b1; dq_oe_o <= 1'b0;
      dq_out_o <= '0; addr_o <= '0;
    end else begin
      we_n_o   <= !(st_next == BC_ACT && wr_next);
      oe_n_o   <= !(st_next == BC_ACT && !wr_next);
      dq_oe_o  <= (st_next != BC_IDLE) && wr_next;
      dq_out_o <= {8'h00, d_next};
      addr_o   <= a_next;
    end
  end
  assign done_o  = done_reg;
  assign rdata_o = rd_reg;
endmodule
`default_nettype wire

// *** fsl_flash_model.sv ***
`default_nettype none
module fsl_flash_model
  import fsl_pkg::*;
(
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        rp_n_i,
  input  wire logic [19:0] addr_i,
  input  wire logic [15:0] dq_i,
  output wire logic [15:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // device state, timed in status reads
  // ----------------------------------------
  int          erase_left = 0;
  int          write_left = 0;
  int          lat        = 0;
  int          bad        = 0;
  logic        esusp      = 1'b0;
  logic        wsusp      = 1'b0;
  logic        stat       = 1'b0;
  logic        setup      = 1'b0;
  logic        vlow       = 1'b0;
  logic        perm       = 1'b0;
  logic [31:0] locks      = '0;
  logic [5:1]  err        = '0;
  logic [15:0] q          = '0;
  logic        busy;
  assign busy = (erase_left > 0 && !esusp) || (write_left > 0 && !wsusp)
                || lat > 0;
  // released bus shows the inverse, never a stale copy
  assign dq_o = oe_n_i ? ~q : q;
  always @(posedge we_n_i) begin
    if (rp_n_i === 1'b1) begin
      if (setup) begin
        setup = 1'b0;
        stat = 1'b1;
        lat = 3;
        case (dq_i[7:0])
          CMD_BLK_LOCK_CF: if (perm) err[4:1] = err[4:1] | 4'h9;
            else locks[addr_i[19:15]] = 1'b1;
          CMD_PERM_LOCK_CF: perm = 1'b1;
          CMD_CLR_LOCK_CF: if (perm) err = err | 5'h11;
            else if (vlow) err = err | 5'h14;
            else locks = '0;
          default: err = err | 5'h18;
        endcase
      end else if ((esusp || wsusp) && dq_i[7:0] != CMD_READ_STATUS
                   && dq_i[7:0] != CMD_RESUME && dq_i[7:0] != CMD_SUSPEND
                   && dq_i[7:0] != CMD_READ_ARRAY) begin
        bad++;
      end else begin
        case (dq_i[7:0])
          CMD_READ_STATUS: stat = 1'b1;
          CMD_READ_ARRAY: stat = 1'b0;
          CMD_CLEAR_STATUS: err = '0;
          CMD_LOCK_SETUP: setup = 1'b1;
          CMD_SUSPEND: begin
            stat = 1'b1;
            lat = 2;
            if (write_left > 0 && !wsusp) wsusp = 1'b1;
            else if (erase_left > 0 && !esusp) esusp = 1'b1;
            else begin
              stat = 1'b0;
              lat = 0;
            end
          end
          CMD_RESUME: begin
            stat = 1'b1;
            lat = 1;
            if (wsusp) wsusp = 1'b0;
            else if (write_left == 0) esusp = 1'b0;
          end
          default: ;
        endcase
      end
    end
  end
  always @(negedge oe_n_i) begin
    if (rp_n_i === 1'b1) begin
      if (stat) q = {8'h00, !busy, esusp, err[5:3], wsusp, err[1], 1'b0};
      else q = 16'ha5a5;
      if (lat > 0) lat--;
      else if (write_left > 0 && !wsusp) write_left--;
      else if (erase_left > 0 && !esusp) erase_left--;
    end
  end
  always @(negedge rp_n_i) begin
    if (esusp || wsusp) bad++;
    if (lat > 0) locks = 'x;
    stat = 1'b0;
  end
endmodule
`default_nettype wire

// *** tb_fsl_ctrl.sv ***
`default_nettype none
module tb_fsl_ctrl
  import fsl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i      = 1'b0;
  logic        reset_i    = 1'b1;
  logic [1:0]  sw_addr_i  = '0;
  logic [31:0] sw_wdata_i = '0;
  logic        sw_write_i = 1'b0;
  logic        sw_read_i  = 1'b0;
  wire  logic [31:0] sw_rdata_o;
  wire  logic [15:0] dq_in;
  wire  logic [15:0] dq_out;
  wire  logic [19:0] faddr;
  wire  logic        dq_oe, we_n, oe_n, rp_n, wp_n;
  int          fail_count = 0;
  int          n_checks   = 0;
  logic [31:0] rng        = 32'd73;
  logic [19:0] la;
  logic [4:0]  blk;
  fsl_ctrl fsl_ctrl_i (.clk_i(clk_i), .reset_i(reset_i),
    .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_write_i(sw_write_i),
    .sw_read_i(sw_read_i), .sw_rdata_o(sw_rdata_o), .dq_in_i(dq_in),
    .dq_out_o(dq_out), .dq_oe_o(dq_oe), .flash_addr_o(faddr), .we_n_o(we_n),
    .oe_n_o(oe_n), .reset_powerdown_n_o(rp_n), .write_protect_n_o(wp_n));
  fsl_flash_model flash_i (.we_n_i(we_n), .oe_n_i(oe_n), .rp_n_i(rp_n),
    .addr_i(faddr), .dq_i(dq_out), .dq_o(dq_in));
  // ----------------------------------------
  // bus tasks and checking
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_write_i <= 1'b1;
    @(posedge clk_i);
    sw_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [31:0] d);
    sw_addr_i <= a;
    sw_read_i <= 1'b1;
    @(posedge clk_i);
    sw_read_i <= 1'b0;
    // sample mid-cycle, clear of the edge that updates the data
    @(negedge clk_i);
    d = sw_rdata_o;
    @(posedge clk_i);
  endtask
  task automatic step(input int act, input logic [2:0] o,
      input logic [4:0] er, input logic [4:0] rm,
      input logic [7:0] es, input logic [7:0] sm);
    logic [31:0] r;
    int          i;
    if (act == 1) flash_i.erase_left = 5;
    if (act == 2) flash_i.write_left = 4;
    if (act == 3) flash_i.vlow = 1'b1;
    if (act == 4) flash_i.vlow = 1'b0;
    rng = xs(rng);
    la = rng[19:0];
    wr(REG_ADDR, {12'h000, la});
    wr(REG_CTRL, {23'h0, 1'b1, 5'h00, o});
    i = 0;
    do begin
      rd(REG_RESULT, r);
      i++;
    end while (r[0] !== 1'b0 && i < 4000);
    chk({26'h0, r[5:0] & {rm, 1'b1}}, {26'h0, er & rm, 1'b0});
    rd(REG_STATUS, r);
    chk(r & {24'h0, sm}, {24'h0, es & sm});
    chk({30'h0, rp_n, wp_n}, 32'h3);
    repeat (20) @(posedge clk_i);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (9) @(posedge clk_i);
    chk({28'h0, rp_n, we_n, oe_n, dq_oe}, 32'h6);
    chk(sw_rdata_o, 32'h0);
    @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    step(1, OP_ERS_SUSP, 5'h03, 5'h1f, 8'hc0, 8'hc0);
    step(0, OP_BLK_LOCK, 5'h10, 5'h11, 8'h00, 8'h00);
    step(2, OP_WR_SUSP, 5'h05, 5'h1d, 8'hc4, 8'hc4);
    step(0, OP_ERS_RES, 5'h10, 5'h11, 8'h00, 8'h00);
    step(0, OP_WR_RES, 5'h01, 5'h1d, 8'hc0, 8'hc4);
    step(0, OP_ERS_RES, 5'h01, 5'h1f, 8'h80, 8'hc4);
    step(0, OP_ERS_SUSP, 5'h01, 5'h1f, 8'h80, 8'hc0);
    step(2, OP_WR_SUSP, 5'h05, 5'h1f, 8'h84, 8'hc4);
    step(0, OP_CLR_LOCK, 5'h10, 5'h11, 8'h00, 8'h00);
    step(0, OP_WR_RES, 5'h01, 5'h1f, 8'h80, 8'hc4);
    step(0, OP_WR_SUSP, 5'h01, 5'h1f, 8'h80, 8'hc4);
    step(0, OP_BLK_LOCK, 5'h01, 5'h1f, 8'h80, 8'hfe);
    blk = la[19:15];
    chk({31'h0, flash_i.locks[blk]}, 32'h1);
    step(3, OP_CLR_LOCK, 5'h00, 5'h1f, 8'ha8, 8'hfe);
    chk({31'h0, flash_i.locks[blk]}, 32'h1);
    step(4, OP_CLR_LOCK, 5'h01, 5'h1f, 8'h80, 8'hfe);
    chk(flash_i.locks, 32'h0);
    step(0, OP_BLK_LOCK, 5'h01, 5'h1f, 8'h80, 8'hfe);
    blk = la[19:15];
    step(0, OP_PERM_LOCK, 5'h01, 5'h1f, 8'h80, 8'hfe);
    chk({31'h0, flash_i.perm}, 32'h1);
    step(0, OP_BLK_LOCK, 5'h00, 5'h1f, 8'h92, 8'hfe);
    step(0, OP_CLR_LOCK, 5'h00, 5'h1f, 8'ha2, 8'hfe);
    chk({30'h0, flash_i.perm, flash_i.locks[blk]}, 32'h3);
    step(0, 3'h0, 5'h10, 5'h11, 8'h00, 8'h00);
    chk(flash_i.bad, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
